// ---- rtl/oms_mode_decode.sv ----
`timescale 1ns/10ps
// Pure decode of the three mode status bits
module oms_mode_decode
    import oms_pkg::*;
(
    input wire logic [2:0] mode_bits_in, // Special-low, select hi, select lo
    output oms_mode_t mode_out, // Decoded mode
    output logic [1:0] port_a_use_out, // Port A function
    output logic [1:0] port_b_use_out // Port B function
);
    logic [1:0] sel; // Select code

    assign sel = mode_bits_in[STRAP_HI_POS:STRAP_LO_POS];

    // Mode table
    always_comb begin
        if (!mode_bits_in[STRAP_BACKGROUND_STRAP_PIN_POS]) begin
            unique case (sel)
                SEL_SINGLE: mode_out = OMS_SPECIAL_SINGLE;
                SEL_NARROW: mode_out = OMS_SPECIAL_NARROW;
                SEL_PERIPH: mode_out = OMS_SPECIAL_PERIPH;
                SEL_WIDE: mode_out = OMS_SPECIAL_WIDE;
            endcase
        end else begin
            unique case (sel)
                SEL_SINGLE: mode_out = OMS_NORMAL_SINGLE;
                SEL_NARROW: mode_out = OMS_NORMAL_NARROW;
                SEL_PERIPH: mode_out = OMS_SPECIAL_PERIPH; // Reserved forced
                SEL_WIDE: mode_out = OMS_NORMAL_WIDE;
            endcase
        end
    end

    // Port usage follows the bus width
    always_comb begin
        unique case (sel)
            SEL_SINGLE: begin
                port_a_use_out = PORT_GPIO;
                port_b_use_out = PORT_GPIO;
            end
            SEL_NARROW: begin
                port_a_use_out = PORT_ADDR_HI_DATA;
                port_b_use_out = PORT_ADDR_LO;
            end
            default: begin // Wide and peripheral
                port_a_use_out = PORT_ADDR_DATA;
                port_b_use_out = PORT_ADDR_DATA;
            end
        endcase
    end
endmodule

// ---- rtl/oms_mode_select.sv ----
`timescale 1ns/10ps
// Contract
// - Latch three straps at reset release
// - Status bits report mode, limited changes
// - Pull-up background, pull-downs selects during reset
// - Open straps give normal single-chip
// - Special modes decode from select code
// - Normal modes decode from select code
// - Reserved combination forced to peripheral
// - Ports follow single, narrow, wide usage
// - Normal protects bits, special allows writes
// - Special single-chip starts monitor active
// - Normal modes: enable before activate
// - Mode sets default map, then relocatable
// - Select bits: once normal, any special
// - Peripheral entered or left only by reset
module oms_mode_select
    import oms_pkg::*;
(
    input wire logic clock_in, // 20 MHz system clock
    input wire logic reset_in, // Async reset, active high
    input wire logic background_strap_pin_in, // Background strap level
    input wire logic mode_select_hi_pin_in, // Select hi strap level
    input wire logic mode_select_lo_pin_in, // Select lo strap level
    input wire logic mode_wr_in, // Software write strobe, select bits
    input wire logic [1:0] mode_wr_data_in, // New {hi, lo} select bits
    input wire logic dbg_enable_cmd_in, // Host enable command pulse
    input wire logic dbg_activate_cmd_in, // Host activate command pulse
    input wire logic dbg_exit_cmd_in, // Monitor leaves active state
    output logic background_pull_up_out, // Pull-up on background pin
    output logic mode_select_hi_pull_down_out, // Pull-down on select hi
    output logic mode_select_lo_pull_down_out, // Pull-down on select lo
    output logic special_mode_low_bit_out, // Low in special modes
    output logic mode_select_hi_out, // Select hi status bit
    output logic mode_select_lo_out, // Select lo status bit
    output oms_mode_t mode_out, // Decoded mode
    output logic special_out, // High in special modes
    output logic protect_lock_out, // Protected registers locked
    output logic [1:0] port_a_use_out, // Port A function
    output logic [1:0] port_b_use_out, // Port B function
    output logic default_map_load_out, // Pulse: load default map
    output logic debug_monitor_enabled_out, // Monitor enabled
    output logic debug_monitor_active_out // Monitor active
);
    logic [2:0] mode_bits_ff; // Latched status bits
    logic in_reset_ff; // High through reset, drops one edge after
    logic sel_written_ff; // Select bits already written once
    logic dbg_enabled_ff; // Monitor enabled
    logic dbg_active_ff; // Monitor active
    logic [2:0] nxt_mode_bits; // Next status bits
    logic wr_ok; // Select write accepted
    logic is_special; // Special mode flag
    logic is_periph; // Peripheral flag

    assign is_special = ~mode_bits_ff[STRAP_BACKGROUND_STRAP_PIN_POS];
    assign is_periph = (mode_out == OMS_SPECIAL_PERIPH);

    // Pulls only while reset holds; strap levels default via pulls
    assign background_pull_up_out = reset_in;
    assign mode_select_hi_pull_down_out = reset_in;
    assign mode_select_lo_pull_down_out = reset_in;

    // Release tracker: first clocked edge after reset drop samples straps
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            in_reset_ff <= 1'b1;
        end else begin
            in_reset_ff <= 1'b0;
        end
    end

    // Write gate: once in normal, any count in special
    // Peripheral cannot be entered or left by software
    assign wr_ok = mode_wr_in && !in_reset_ff && !is_periph
        && (mode_wr_data_in != SEL_PERIPH) && (is_special || !sel_written_ff);

    // Next status bits
    always_comb begin
        nxt_mode_bits = mode_bits_ff; // Hold otherwise
        if (in_reset_ff) begin
            // Straps captured at the first clock edge after reset release
            nxt_mode_bits = {background_strap_pin_in, mode_select_hi_pin_in,
                mode_select_lo_pin_in};
        end else if (wr_ok) begin
            nxt_mode_bits[STRAP_HI_POS:STRAP_LO_POS] = mode_wr_data_in;
        end
    end

    // Status bits; async reset takes a constant only
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            mode_bits_ff <= STRAP_RESET_DEFAULT;
        end else begin
            mode_bits_ff <= nxt_mode_bits;
        end
    end

    // Write-once tracking
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            sel_written_ff <= 1'b0;
        end else if (wr_ok) begin
            sel_written_ff <= 1'b1;
        end
    end

    // Default map load held high through reset, dropping as the latched mode takes effect
    assign default_map_load_out = in_reset_ff;

    oms_mode_decode u_decode (
        .mode_bits_in(mode_bits_ff),
        .mode_out(mode_out),
        .port_a_use_out(port_a_use_out),
        .port_b_use_out(port_b_use_out)
    );

    // Debug monitor enable
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            dbg_enabled_ff <= 1'b0;
        end else if (in_reset_ff) begin
            // Enabled from release in special single-chip
            dbg_enabled_ff <= !background_strap_pin_in && !mode_select_hi_pin_in
                && !mode_select_lo_pin_in;
        end else if (dbg_enable_cmd_in && !is_periph) begin
            dbg_enabled_ff <= 1'b1;
        end
    end

    // Debug monitor active; never before enabled
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            dbg_active_ff <= 1'b0;
        end else if (in_reset_ff) begin
            dbg_active_ff <= !background_strap_pin_in && !mode_select_hi_pin_in
                && !mode_select_lo_pin_in;
        end else if (dbg_activate_cmd_in && dbg_enabled_ff) begin
            dbg_active_ff <= 1'b1;
        end else if (dbg_exit_cmd_in) begin
            dbg_active_ff <= 1'b0;
        end
    end

    // Status outputs
    assign special_mode_low_bit_out = mode_bits_ff[STRAP_BACKGROUND_STRAP_PIN_POS];
    assign mode_select_hi_out = mode_bits_ff[STRAP_HI_POS];
    assign mode_select_lo_out = mode_bits_ff[STRAP_LO_POS];
    assign special_out = is_special;
    assign protect_lock_out = !is_special; // Normal modes lock
    assign debug_monitor_enabled_out = dbg_enabled_ff;
    assign debug_monitor_active_out = dbg_active_ff;
endmodule

// ---- rtl/oms_pkg.sv ----
package oms_pkg;
    // Strap code bit positions: {background, select hi, select lo}
    localparam int STRAP_BACKGROUND_STRAP_PIN_POS = 2; // Background strap bit
    localparam int STRAP_HI_POS = 1; // Select hi bit
    localparam int STRAP_LO_POS = 0; // Select lo bit
    localparam logic [2:0] STRAP_RESET_DEFAULT = 3'h4; // Normal single-chip value
    localparam logic [1:0] SEL_SINGLE = 2'h0; // Single-chip select code
    localparam logic [1:0] SEL_NARROW = 2'h1; // Expanded narrow select code
    localparam logic [1:0] SEL_PERIPH = 2'h2; // Peripheral / reserved code
    localparam logic [1:0] SEL_WIDE = 2'h3; // Expanded wide select code
    localparam logic [1:0] PORT_GPIO = 2'h0; // Port as general I/O
    localparam logic [1:0] PORT_ADDR_HI_DATA = 2'h1; // High address muxed with data
    localparam logic [1:0] PORT_ADDR_LO = 2'h2; // Low address only
    localparam logic [1:0] PORT_ADDR_DATA = 2'h3; // Full address/data mux

    // Operating modes
    typedef enum logic [2:0] {
        OMS_SPECIAL_SINGLE,
        OMS_SPECIAL_NARROW,
        OMS_SPECIAL_PERIPH,
        OMS_SPECIAL_WIDE,
        OMS_NORMAL_SINGLE,
        OMS_NORMAL_NARROW,
        OMS_NORMAL_WIDE
    } oms_mode_t;
endpackage

// ---- verif/oms_mode_select_assertions.sv ----
`timescale 1ns/10ps
// Capture, hold, lock and monitor start-up seen at the top ports
module oms_mode_select_assertions
    import oms_pkg::*;
(
    input wire logic clock_in, // Clock
    input wire logic reset_in, // Reset
    input wire logic background_strap_pin_in, // Strap
    input wire logic mode_select_hi_pin_in, // Strap
    input wire logic mode_select_lo_pin_in, // Strap
    input wire logic mode_wr_in, // Write strobe
    input wire logic [1:0] mode_wr_data_in, // Write data
    input wire logic special_mode_low_bit_out, // Status
    input wire logic mode_select_hi_out, // Status
    input wire logic mode_select_lo_out, // Status
    input wire oms_mode_t mode_out, // Mode
    input wire logic special_out, // Special
    input wire logic protect_lock_out, // Lock
    input wire logic default_map_load_out, // Map pulse
    input wire logic debug_monitor_enabled_out, // Enabled
    input wire logic debug_monitor_active_out // Active
);
    wire logic [2:0] st = {special_mode_low_bit_out, mode_select_hi_out, mode_select_lo_out};
    wire logic [2:0] pin = {background_strap_pin_in, mode_select_hi_pin_in, mode_select_lo_pin_in};
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    a_strap_capture: assert property ($past(reset_in) |=> st == $past(pin))
        else $error("straps not captured");
    a_bits_hold: assert property (!mode_wr_in && !$past(reset_in) |=> $stable(st))
        else $error("status bits moved");
    a_sel_refused: assert property (mode_wr_in && mode_wr_data_in == SEL_PERIPH |=> $stable(st))
        else $error("peripheral write taken");
    a_periph_kept: assert property (mode_out == OMS_SPECIAL_PERIPH |=> $stable(mode_out))
        else $error("peripheral left");
    a_lock_normal: assert property (protect_lock_out == st[2] && special_out != st[2])
        else $error("lock wrong");
    a_map_pulse: assert property (default_map_load_out == $past(reset_in))
        else $error("map pulse wrong");
    a_enable_first: assert property (debug_monitor_active_out |-> debug_monitor_enabled_out)
        else $error("monitor active unenabled");
    a_single_debug: assert property ($past(reset_in) && pin == 3'h0 |=> debug_monitor_active_out)
        else $error("monitor not active");
endmodule
bind oms_mode_select oms_mode_select_assertions u_chk (.*);

// ---- verif/oms_strap_board.sv ----
`timescale 1ns/10ps
// Board straps: tied to a level, or left open and held only by the chip's pulls
module oms_strap_board (
    input wire logic clock_in, // System clock
    input wire logic [2:0] tie_en_in, // Strap tied on the board
    input wire logic [2:0] tie_val_in, // Tied level
    input wire logic [2:0] pull_in, // Chip pulls on
    output logic [2:0] pin_out // {background, select hi, select lo}
);
    int age = 0; // Cycles since the pulls let go
    // Open pins keep the pulled level two cycles, then float and toggle
    always @(posedge clock_in) age <= (|pull_in) ? 0 : age + 1;
    // Pulls give background high, selects low
    assign pin_out = (tie_en_in & tie_val_in)
        | (~tie_en_in & ((age < 2) ? 3'h4 : (age[0] ? 3'h3 : 3'h4)));
endmodule

// ---- verif/test_operating_mode_select.sv ----
`timescale 1ns/10ps
// Sweeps every strap code and open pins, then mode writes and host commands
module test_operating_mode_select;
    import oms_pkg::*;
    logic clock_in = 1'b0, reset_in = 1'b1, mode_wr_in = 1'b0; // Clock, reset, strobe
    logic dbg_enable_cmd_in = 1'b0, dbg_activate_cmd_in = 1'b0, dbg_exit_cmd_in = 1'b0; // Host
    logic [1:0] mode_wr_data_in = 2'h0, port_a_use_out, port_b_use_out; // Data, ports
    logic [2:0] tie_en = 3'h7, tie_val = 3'h4, eb; // Board ties, expected bits
    wire logic background_strap_pin_in, mode_select_hi_pin_in, mode_select_lo_pin_in; // Straps
    logic background_pull_up_out, mode_select_hi_pull_down_out, mode_select_lo_pull_down_out;
    logic special_mode_low_bit_out, mode_select_hi_out, mode_select_lo_out, special_out;
    logic protect_lock_out, default_map_load_out, debug_monitor_enabled_out;
    logic debug_monitor_active_out; // Monitor state
    oms_mode_t mode_out; // Decoded mode
    bit wrote, een, eact; // Model state
    int seed = 32'h17CB33F2, n_mismatch = 0, checks = 0, cyc = 0; // Seed, counters
    // Expected mode indexed by status bits, {port A, port B} use indexed by select bits
    oms_mode_t mtab [8] = '{OMS_SPECIAL_SINGLE, OMS_SPECIAL_NARROW, OMS_SPECIAL_PERIPH,
        OMS_SPECIAL_WIDE, OMS_NORMAL_SINGLE, OMS_NORMAL_NARROW, OMS_SPECIAL_PERIPH, OMS_NORMAL_WIDE};
    logic [3:0] ptab [4] = '{4'h0, 4'h6, 4'hF, 4'hF};
    oms_mode_select dut (.*);
    oms_strap_board board (.clock_in, .tie_en_in(tie_en), .tie_val_in(tie_val),
        .pull_in({background_pull_up_out, mode_select_hi_pull_down_out,
            mode_select_lo_pull_down_out}),
        .pin_out({background_strap_pin_in, mode_select_hi_pin_in, mode_select_lo_pin_in}));
    always #25 clock_in = ~clock_in;
    // Hang guard, far above the roughly 190 cycles needed
    always @(posedge clock_in) begin
        cyc++;
        if (cyc > 2000) begin
            n_mismatch++;
            close_out;
        end
    end
    task automatic note(input bit bad);
        checks++;
        if (bad) begin
            n_mismatch++;
            $display("wrong value at %0t: mode %0d expected bits %h", $time, mode_out, eb);
        end
    endtask
    task cmp_mode;
        note({special_mode_low_bit_out, mode_select_hi_out, mode_select_lo_out, special_out,
            protect_lock_out, port_a_use_out, port_b_use_out, mode_out}
            !== {eb, !eb[2], eb[2], ptab[eb[1:0]], mtab[eb]});
    endtask
    task cmp_dbg;
        note({debug_monitor_enabled_out, debug_monitor_active_out} !== {een, eact});
    endtask
    // Pulls and default map load all follow reset
    task cmp_pull(input bit exp);
        note({background_pull_up_out, mode_select_hi_pull_down_out,
            mode_select_lo_pull_down_out, default_map_load_out} !== {4{exp}});
    endtask
    // One-cycle strobe launched and dropped on falling edges
    task automatic pulse(ref logic s);
        @(negedge clock_in) s = 1'b1;
        @(negedge clock_in) s = 1'b0;
    endtask
    task close_out;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clock_in);
        // Codes 0 to 7 tied, code 8 all pins open
        for (int c = 0; c < 9; c++) begin
            reset_in = 1'b1;
            tie_en = (c < 8) ? 3'h7 : 3'h0;
            tie_val = c[2:0];
            @(negedge clock_in) cmp_pull(1'b1);
            @(negedge clock_in) reset_in = 1'b0;
            @(negedge clock_in);
            eb = (c < 8) ? c[2:0] : 3'h4;
            wrote = 1'b0;
            een = (c == 0);
            eact = een;
            cmp_mode;
            cmp_dbg;
            cmp_pull(1'b0);
            tie_en = 3'h7;
            tie_val = 3'($random(seed));
            @(negedge clock_in) cmp_mode;
            // Random writes, then a refused peripheral code
            for (int k = 0; k < 4; k++) begin
                mode_wr_data_in = (k == 3) ? SEL_PERIPH : 2'($random(seed));
                if (mtab[eb] != OMS_SPECIAL_PERIPH && mode_wr_data_in != SEL_PERIPH
                    && (!eb[2] || !wrote)) begin
                    eb[1:0] = mode_wr_data_in;
                    wrote = 1'b1;
                end
                pulse(mode_wr_in);
                cmp_mode;
            end
            pulse(dbg_activate_cmd_in);
            cmp_dbg;
            pulse(dbg_enable_cmd_in);
            een = een || (mtab[eb] != OMS_SPECIAL_PERIPH);
            cmp_dbg;
            pulse(dbg_activate_cmd_in);
            eact = een;
            cmp_dbg;
            pulse(dbg_exit_cmd_in);
            eact = 1'b0;
            cmp_dbg;
        end
        close_out;
    end
endmodule
